// ### design/fmc_meas_config.sv
// measurement configuration registers and the logic that applies them
`include "fmc_consts.svh"
`default_nettype none
module fmc_meas_config #(
  parameter int CHG0_CYC = (`FMC_T_CHG0_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS,
  parameter int CHG1_CYC = (`FMC_T_CHG1_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS,
  parameter int CHG2_CYC = (`FMC_T_CHG2_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS,
  parameter int CHG3_CYC = (`FMC_T_CHG3_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS,
  parameter int OSC2_CYC = (`FMC_T_OSC2_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS,
  parameter int OSC3_CYC = (`FMC_T_OSC3_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS,
  parameter int OSC4_CYC = (`FMC_T_OSC4_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS,
  parameter int OSC5_CYC = (`FMC_T_OSC5_NS + `FMC_CLK_NS - 1) / `FMC_CLK_NS,
  parameter int H50_CYC  = (`FMC_T_P50_NS + 2 * `FMC_CLK_NS - 1) / (2 * `FMC_CLK_NS),
  parameter int H60_CYC  = (`FMC_T_P60_NS + 2 * `FMC_CLK_NS - 1) / (2 * `FMC_CLK_NS)
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  // converter core
  input  wire logic        meas_start_i,
  input  wire logic        meas_active_i,
  input  wire logic        meas_mode2_i,
  input  wire logic        nvm_done_i,
  input  wire logic        tof_first_done_i,
  input  wire logic        temp_first_done_i,
  output logic             tof_second_go_o,
  output logic             temp_second_go_o,
  output logic             quad_resolution_o,
  output logic             double_resolution_o,
  // stop and sense inputs
  input  wire logic        stop_dig_a_i,
  input  wire logic        stop_dig_b_i,
  input  wire logic        stop_ana_a_i,
  input  wire logic        stop_ana_b_i,
  input  wire logic        temp_sense_i,
  output logic             stop_input_a_o,
  output logic             stop_input_b_o,
  output logic             temp_sense_o,
  // analog section
  output logic             analog_sel_o,
  output logic             analog_power_o,
  output logic      [3:0]  comparator_offset_o,
  output logic             charge_busy_o,
  // high-speed oscillator
  output logic             hs_osc_en_o,
  output logic             hs_osc_ready_o,
  // temperature unit
  input  wire logic [1:0]  temp_step_i,
  output logic      [1:0]  temp_port_sel_o,
  // fire pulse generator
  input  wire logic        fire_up_act_i,
  input  wire logic        fire_down_act_i,
  input  wire logic        fire_pulse_i,
  output logic             fire_up_o,
  output logic             fire_up_oe_o,
  output logic             fire_down_o,
  output logic             fire_down_oe_o,
  output logic      [6:0]  fire_pulse_count_o,
  output logic             fire_phase_inv_o
);
  import fmc_pkg::*;
  localparam int W = `FMC_TMR_W;

  fmc_state_t          q;
  fmc_state_t          d;
  logic                req;
  logic                rd_clr;
  logic [31:0]         rd_val;
  logic [`FMC_NEV-1:0] status;
  logic [`FMC_NEV-1:0] ev_set;
  logic                chg_busy;
  logic                chg_done;
  logic                chg_start;
  logic [W-1:0]        chg_load;
  logic                osc_done;
  logic                osc_start;
  logic                osc_abort;
  logic [W-1:0]        osc_load;
  logic                pair_busy;
  logic                pair_done;
  logic                pair_start;
  logic [W-1:0]        pair_load;
  logic [1:0]          pair_code;
  logic [2:0]          pair_mult;
  logic [2:0]          osc_mode;

  assign req    = wb_cyc_i && wb_stb_i;
  assign rd_clr = req && !q.ack && !wb_we_i && (wb_adr_i == `FMC_ADR_STAT);

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (wb_adr_i)
      `FMC_ADR_CFG:  rd_val = q.cfg;
      `FMC_ADR_ID:   rd_val = {24'h00_0000, q.id};
      `FMC_ADR_STAT: rd_val = {{(32 - `FMC_NEV){1'b0}}, status};
      `FMC_ADR_MASK: rd_val = {{(32 - `FMC_NEV){1'b0}}, q.mask};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // timer loads
  // ----------------------------------------------------------------
  always_comb begin
    case (q.cfg[`FMC_F_CHG])
      2'h0:    chg_load = W'(CHG0_CYC);
      2'h1:    chg_load = W'(CHG1_CYC);
      2'h2:    chg_load = W'(CHG2_CYC);
      default: chg_load = W'(CHG3_CYC);
    endcase
  end

  assign osc_mode = q.cfg[`FMC_F_OSC];
  always_comb begin
    case (osc_mode)
      3'h2:    osc_load = W'(OSC2_CYC);
      3'h3:    osc_load = W'(OSC3_CYC);
      3'h4:    osc_load = W'(OSC4_CYC);
      default: osc_load = W'(OSC5_CYC);
    endcase
  end

  // delay in half periods: codes 0..3 give 2..5 halves
  assign pair_code = tof_first_done_i ? q.cfg[`FMC_F_FCYC] : q.cfg[`FMC_F_TCYC];
  assign pair_mult = {1'b0, pair_code} + 3'h2;
  always_comb begin
    if (q.cfg[`FMC_B_MAINS_BASE_SELECT]) begin
      pair_load = W'(H60_CYC * int'(pair_mult));
    end else begin
      pair_load = W'(H50_CYC * int'(pair_mult));
    end
  end

  assign chg_start  = meas_start_i && q.cfg[`FMC_B_ANALOG];
  assign osc_start  = (q.osc == FMC_OSC_IDLE) && meas_start_i && (osc_mode >= 3'h2);
  assign osc_abort  = osc_mode < 3'h2;
  assign pair_start = (tof_first_done_i || temp_first_done_i) && !pair_busy;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ack = 1'b0;
    if (req && !q.ack) begin
      d.ack = 1'b1;
      d.dat = rd_val;
      if (wb_we_i) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b] && wb_adr_i == `FMC_ADR_CFG) begin
            d.cfg[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
        d.cfg = d.cfg & `FMC_CFG_WMASK;
        if (wb_sel_i[0] && wb_adr_i == `FMC_ADR_ID) begin
          d.id = wb_dat_i[7:0];
        end
        if (wb_sel_i[0] && wb_adr_i == `FMC_ADR_MASK) begin
          d.mask = wb_dat_i[`FMC_NEV-1:0];
        end
      end
    end
    case (q.osc)
      FMC_OSC_IDLE: begin
        if (osc_start) begin
          d.osc = FMC_OSC_WAIT;
        end
      end
      FMC_OSC_WAIT: begin
        if (osc_abort) begin
          d.osc = FMC_OSC_IDLE;
        end else if (osc_done) begin
          d.osc = FMC_OSC_RUN;
        end
      end
      FMC_OSC_RUN: begin
        if (osc_abort || !meas_active_i) begin
          d.osc = FMC_OSC_IDLE;
        end
      end
      default: d.osc = FMC_OSC_IDLE;
    endcase
    if (pair_start) begin
      d.pair_tof = tof_first_done_i;
    end
    d.tof_go  = pair_done && q.pair_tof;
    d.temp_go = pair_done && !q.pair_tof;
    // active buffer fires, the other drives the idle level only when FMC_B_FIDLE is set
    d.fu_o  = fire_up_act_i && fire_pulse_i;
    d.fu_oe = fire_up_act_i || q.cfg[`FMC_B_FIDLE];
    d.fd_o  = fire_down_act_i && fire_pulse_i;
    d.fd_oe = fire_down_act_i || q.cfg[`FMC_B_FIDLE];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q          <= '0;
      q.cfg      <= `FMC_CFG_RST;
      q.id       <= `FMC_ID_RST;
      q.osc      <= FMC_OSC_IDLE;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // timers and interrupts
  // ----------------------------------------------------------------
  fmc_delay_timer #(.W(W)) u_chg (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (chg_start),
    .abort_i (1'b0),
    .load_i  (chg_load),
    .busy_o  (chg_busy),
    .done_o  (chg_done)
  );
  fmc_delay_timer #(.W(W)) u_osc (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (osc_start),
    .abort_i (osc_abort),
    .load_i  (osc_load),
    .busy_o  (),
    .done_o  (osc_done)
  );
  fmc_delay_timer #(.W(W)) u_pair (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (pair_start),
    .abort_i (1'b0),
    .load_i  (pair_load),
    .busy_o  (pair_busy),
    .done_o  (pair_done)
  );

  assign ev_set[`FMC_EV_NVM]  = nvm_done_i && q.cfg[`FMC_B_NVMIE];
  assign ev_set[`FMC_EV_PAIR] = pair_done;
  assign ev_set[`FMC_EV_CHG]  = chg_done;

  fmc_irq_bank u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .set_i    (ev_set),
    .rd_clr_i (rd_clr),
    .mask_i   (q.mask),
    .status_o (status),
    .irq_o    (irq_o)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;

  assign analog_sel_o   = q.cfg[`FMC_B_ANALOG];
  assign analog_power_o = q.cfg[`FMC_B_ANALOG] && meas_active_i;
  assign stop_input_a_o = q.cfg[`FMC_B_ANALOG] ? stop_ana_a_i : stop_dig_a_i;
  assign stop_input_b_o = !(q.cfg[`FMC_B_DBL] && !meas_mode2_i) &&
                          (q.cfg[`FMC_B_ANALOG] ? stop_ana_b_i : stop_dig_b_i);
  assign temp_sense_o   = temp_sense_i ^ q.cfg[`FMC_B_TINV];
  assign comparator_offset_o = q.cfg[`FMC_F_OFS];
  assign charge_busy_o  = chg_busy;

  assign hs_osc_en_o    = (osc_mode == 3'h1) || (q.osc != FMC_OSC_IDLE && !osc_abort);
  assign hs_osc_ready_o = (osc_mode < 3'h2) || (q.osc == FMC_OSC_RUN);

  assign tof_second_go_o  = q.tof_go;
  assign temp_second_go_o = q.temp_go;
  assign quad_resolution_o   = q.cfg[`FMC_B_QUAD] && meas_mode2_i;
  assign double_resolution_o = q.cfg[`FMC_B_DBL];

  assign temp_port_sel_o = q.cfg[`FMC_B_PORD] ? ~temp_step_i : temp_step_i;

  assign fire_up_o      = q.fu_o;
  assign fire_up_oe_o   = q.fu_oe;
  assign fire_down_o    = q.fd_o;
  assign fire_down_oe_o = q.fd_oe;
  assign fire_pulse_count_o = q.cfg[`FMC_F_NFIRE];
  assign fire_phase_inv_o   = q.cfg[`FMC_B_PHINV] &&
                              (q.cfg[`FMC_F_NFIRE] <= `FMC_PHINV_MAX);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_cfg_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `FMC_ADR_CFG && wb_sel_i[0];
  endsequence
  sequence s_osc_go;
    meas_start_i && (osc_mode >= 3'h2) && (q.osc == FMC_OSC_IDLE);
  endsequence

  a_analog_power: assert property (analog_power_o |-> meas_active_i && analog_sel_o)
    else $error("analog powered outside measurement");
  a_stop_route: assert property ((analog_sel_o && !stop_ana_a_i) |-> !stop_input_a_o)
    else $error("stop a not taken from analog path");
  a_temp_invert: assert property ((q.cfg[`FMC_B_TINV] && temp_sense_i) |-> !temp_sense_o)
    else $error("temperature sense not inverted");
  a_offset_write: assert property (s_cfg_wr |=> comparator_offset_o == $past(wb_dat_i[5:2]))
    else $error("comparator offset not taken from write");
  a_nvm_irq: assert property (
    (nvm_done_i && q.cfg[`FMC_B_NVMIE] && q.mask[`FMC_EV_NVM]) |=> irq_o)
    else $error("memory action end gave no interrupt");
  a_osc_settle: assert property (s_osc_go |=> hs_osc_en_o && !hs_osc_ready_o)
    else $error("oscillator ready without settling");
  a_osc_off: assert property ((osc_mode == 3'h0) |-> !hs_osc_en_o)
    else $error("oscillator on in off mode");
  a_pair_start: assert property ((tof_first_done_i && !pair_busy) |=> pair_busy)
    else $error("flight pair delay not started");
  a_pair_go: assert property (tof_second_go_o |-> $past(pair_done))
    else $error("second measurement without delay");
  a_fire_idle: assert property (
    (fire_up_act_i && !fire_down_act_i && q.cfg[`FMC_B_FIDLE]) |=> fire_down_oe_o && !fire_down_o)
    else $error("idle fire buffer not driven low");
  a_quad_mode: assert property (quad_resolution_o |-> meas_mode2_i)
    else $error("quad resolution outside second mode");
  a_double_stop: assert property ((double_resolution_o && !meas_mode2_i) |-> !stop_input_b_o)
    else $error("stop b passed in double resolution");
  a_port_order: assert property (q.cfg[`FMC_B_PORD] |-> temp_port_sel_o == 2'h3 - temp_step_i)
    else $error("temperature port order wrong");
  a_phase_limit: assert property (fire_phase_inv_o |-> fire_pulse_count_o <= 7'h0F)
    else $error("phase invert above pulse limit");
endmodule : fmc_meas_config
`default_nettype wire

// ### design/fmc_consts.svh
// register map, field positions and timing figures of the measurement config block
`ifndef FMC_CONSTS_SVH
`define FMC_CONSTS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define FMC_ADR_CFG   8'h00
`define FMC_ADR_ID    8'h04
`define FMC_ADR_STAT  8'h08
`define FMC_ADR_MASK  8'h0C
`define FMC_CFG_RST   32'h0000_00C0
`define FMC_CFG_WMASK 32'h1FFF_FFFF
`define FMC_ID_RST    8'h00
// ----------------------------------------------------------------
// config word fields
// ----------------------------------------------------------------
`define FMC_B_ANALOG  0
`define FMC_B_TINV    1
`define FMC_F_OFS     5:2
`define FMC_F_CHG     7:6
`define FMC_B_NVMIE   8
`define FMC_F_OSC     11:9
`define FMC_F_TCYC    13:12
`define FMC_F_FCYC    15:14
`define FMC_B_MAINS_BASE_SELECT    16
`define FMC_B_FIDLE   17
`define FMC_B_QUAD    18
`define FMC_B_DBL     19
`define FMC_B_PORD    20
`define FMC_F_NFIRE   27:21
`define FMC_B_PHINV   28
`define FMC_PHINV_MAX 7'h0F
// ----------------------------------------------------------------
// event bits of status and mask
// ----------------------------------------------------------------
`define FMC_EV_NVM    0
`define FMC_EV_PAIR   1
`define FMC_EV_CHG    2
`define FMC_NEV       3
// ----------------------------------------------------------------
// timing, in ns, and timer width in bits
// ----------------------------------------------------------------
`define FMC_CLK_NS    10
`define FMC_T_CHG0_NS 90000
`define FMC_T_CHG1_NS 120000
`define FMC_T_CHG2_NS 150000
`define FMC_T_CHG3_NS 300000
`define FMC_T_OSC2_NS 480000
`define FMC_T_OSC3_NS 1460000
`define FMC_T_OSC4_NS 2440000
`define FMC_T_OSC5_NS 5140000
`define FMC_T_P50_NS  20000000
`define FMC_T_P60_NS  16670000
`define FMC_TMR_W     24
`endif

// ### design/fmc_pkg.sv
// types shared by the measurement config block
`include "fmc_consts.svh"
`default_nettype none
package fmc_pkg;
  typedef enum logic [2:0] {
    FMC_OSC_IDLE = 3'b001,
    FMC_OSC_WAIT = 3'b010,
    FMC_OSC_RUN  = 3'b100
  } fmc_osc_t;

  typedef struct packed {
    logic [`FMC_NEV-1:0] status;
  } fmc_irq_t;

  typedef struct packed {
    logic [31:0]         cfg;
    logic [7:0]          id;
    logic [`FMC_NEV-1:0] mask;
    logic                ack;
    logic [31:0]         dat;
    fmc_osc_t            osc;
    logic                pair_tof;
    logic                fu_o;
    logic                fu_oe;
    logic                fd_o;
    logic                fd_oe;
    logic                tof_go;
    logic                temp_go;
  } fmc_state_t;
endpackage : fmc_pkg
`default_nettype wire

// ### design/fmc_delay_timer.sv
// one-shot countdown timer, busy for load_i cycles, or one cycle if load_i is zero, then a done pulse
`include "fmc_consts.svh"
`default_nettype none
module fmc_delay_timer #(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // control
  input  wire logic         start_i,
  input  wire logic         abort_i,
  input  wire logic [W-1:0] load_i,
  // status
  output logic              busy_o,
  output logic              done_o
);
  import fmc_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
    logic         done;
  } fmc_tmr_t;
  fmc_tmr_t q;
  fmc_tmr_t d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    if (abort_i) begin
      d.busy = 1'b0;
    end else if (start_i && !q.busy) begin
      d.busy = 1'b1;
      d.cnt  = (load_i == '0) ? W'(1) : load_i;
    end else if (q.busy) begin
      if (q.cnt == W'(1)) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
      d.cnt = q.cnt - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign busy_o = q.busy;
  assign done_o = q.done;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [W-1:0] len_q;
  logic [W-1:0] run_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      len_q <= '0;
      run_q <= '0;
    end else if (start_i && !q.busy && !abort_i) begin
      len_q <= (load_i == '0) ? W'(1) : load_i;
      run_q <= '0;
    end else if (q.busy) begin
      run_q <= run_q + W'(1);
    end
  end
  a_timer_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(done_o) |-> run_q == len_q)
    else $error("timer busy time differs from its load");
endmodule : fmc_delay_timer
`default_nettype wire

// ### design/fmc_irq_bank.sv
// sticky event flags, cleared by a status read, masked onto one interrupt
`include "fmc_consts.svh"
`default_nettype none
module fmc_irq_bank (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // events and control
  input  wire logic [`FMC_NEV-1:0] set_i,
  input  wire logic                rd_clr_i,
  input  wire logic [`FMC_NEV-1:0] mask_i,
  // state
  output logic      [`FMC_NEV-1:0] status_o,
  output logic                     irq_o
);
  import fmc_pkg::*;
  fmc_irq_t q;
  fmc_irq_t d;

  // a set in the clearing cycle survives
  always_comb begin
    d = q;
    d.status = (rd_clr_i ? '0 : q.status) | set_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign status_o = q.status;
  assign irq_o    = |(q.status & mask_i);

  a_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (|set_i) |=> ((status_o & $past(set_i)) == $past(set_i)))
    else $error("event lost in clearing cycle");
endmodule : fmc_irq_bank
`default_nettype wire

// ### sim/fmc_tb.sv
// self-checking bench of the measurement config block
`include "fmc_consts.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int CH[4] = '{5, 6, 7, 8};
  localparam int OS[4] = '{10, 11, 12, 13};
  localparam int H50   = 20;
  localparam int H60   = 17;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, irq_o, tof_second_go_o, temp_second_go_o, quad_resolution_o;
  logic        meas_start_i = 1'b0, meas_active_i = 1'b0, meas_mode2_i = 1'b0;
  logic        nvm_done_i = 1'b0, tof_first_done_i = 1'b0, temp_first_done_i = 1'b0;
  logic        stop_dig_a_i = 1'b0, stop_dig_b_i = 1'b0, stop_ana_a_i = 1'b1;
  logic        stop_ana_b_i = 1'b1, temp_sense_i = 1'b1, double_resolution_o;
  logic        stop_input_a_o, stop_input_b_o, temp_sense_o, analog_sel_o, analog_power_o;
  logic [3:0]  comparator_offset_o;
  logic        charge_busy_o, hs_osc_en_o, hs_osc_ready_o;
  logic [1:0]  temp_step_i = 2'h1, temp_port_sel_o;
  logic        fire_up_act_i = 1'b0, fire_down_act_i = 1'b0, fire_pulse_i = 1'b0;
  logic        fire_up_o, fire_up_oe_o, fire_down_o, fire_down_oe_o, fire_phase_inv_o;
  logic [6:0]  fire_pulse_count_o;
  int          fails = 0;
  int          check_count = 0;
  always #5 clk_i = ~clk_i;
  fmc_meas_config #(
    .CHG0_CYC(CH[0]), .CHG1_CYC(CH[1]), .CHG2_CYC(CH[2]), .CHG3_CYC(CH[3]),
    .OSC2_CYC(OS[0]), .OSC3_CYC(OS[1]), .OSC4_CYC(OS[2]), .OSC5_CYC(OS[3]),
    .H50_CYC(H50), .H60_CYC(H60)
  ) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq_o, .meas_start_i, .meas_active_i, .meas_mode2_i,
    .nvm_done_i, .tof_first_done_i, .temp_first_done_i, .tof_second_go_o,
    .temp_second_go_o, .quad_resolution_o, .double_resolution_o, .stop_dig_a_i, .stop_dig_b_i,
    .stop_ana_a_i, .stop_ana_b_i, .temp_sense_i, .stop_input_a_o, .stop_input_b_o,
    .temp_sense_o, .analog_sel_o, .analog_power_o, .comparator_offset_o, .charge_busy_o,
    .hs_osc_en_o, .hs_osc_ready_o, .temp_step_i, .temp_port_sel_o, .fire_up_act_i,
    .fire_down_act_i, .fire_pulse_i, .fire_up_o, .fire_up_oe_o, .fire_down_o,
    .fire_down_oe_o, .fire_pulse_count_o, .fire_phase_inv_o
  );
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t %s: got %h want %h", $time, m, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(n, 32'h2, "ack latency");
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    wb(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask : rd
  task automatic pulse(input int s);
    @(posedge clk_i);
    case (s)
      0: meas_start_i <= 1'b1;
      1: nvm_done_i <= 1'b1;
      2: tof_first_done_i <= 1'b1;
      default: temp_first_done_i <= 1'b1;
    endcase
    @(posedge clk_i);
    {meas_start_i, nvm_done_i, tof_first_done_i, temp_first_done_i} <= 4'h0;
  endtask : pulse
  task automatic sample();
    @(posedge clk_i);
    #1;
  endtask : sample
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(`FMC_ADR_CFG, 32'h0000_00C0, "cfg reset");
    rd(`FMC_ADR_ID, 32'h0, "id reset");
    rd(`FMC_ADR_MASK, 32'h0, "mask reset");
    rd(`FMC_ADR_STAT, 32'h0, "stat reset");
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, "unmapped read");
    rd(`FMC_ADR_CFG, 32'h0000_00C0, "unmapped write");
    wr(`FMC_ADR_ID, 32'h0000_005A);
    rd(`FMC_ADR_ID, 32'h0000_005A, "id byte");
    $display("regs test done");
  endtask : t_regs
  task automatic t_fields();
    wr(`FMC_ADR_CFG, 32'hF21E_00E3);
    rd(`FMC_ADR_CFG, 32'h121E_00E3, "cfg readback");
    meas_active_i <= 1'b1;
    sample();
    chk(comparator_offset_o, 32'h8, "offset");
    chk({fire_phase_inv_o, fire_pulse_count_o}, 32'h10, "count 16");
    chk({analog_sel_o, analog_power_o, stop_input_a_o}, 32'h7, "analog");
    chk({double_resolution_o, quad_resolution_o, stop_input_b_o}, 32'h4, "mode one");
    chk({temp_sense_o, temp_port_sel_o}, 32'h2, "sense rev");
    @(posedge clk_i);
    meas_mode2_i <= 1'b1;
    sample();
    chk({double_resolution_o, quad_resolution_o, stop_input_b_o}, 32'h7, "mode two");
    wr(`FMC_ADR_CFG, 32'h11E0_00C0);
    {meas_mode2_i, temp_sense_i, temp_step_i} <= 4'h2;
    sample();
    chk(fire_phase_inv_o, 32'h1, "phase 15");
    chk({analog_sel_o, analog_power_o, stop_input_a_o}, 32'h0, "digital");
    chk({temp_sense_o, temp_port_sel_o}, 32'h2, "sense fwd");
    @(posedge clk_i);
    meas_active_i <= 1'b0;
    $display("fields test done");
  endtask : t_fields
  task automatic t_charge();
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(`FMC_ADR_CFG, 32'h0002_0001 | 32'(c << 6));
      wr(`FMC_ADR_MASK, (c == 0) ? 32'h0 : 32'h4);
      pulse(0);
      n = 0;
      repeat (40) begin
        #1;
        if (charge_busy_o === 1'b1) n++;
        @(posedge clk_i);
      end
      chk(n, CH[c], "charge time");
      #1;
      chk(irq_o, c != 0, "charge irq");
      rd(`FMC_ADR_STAT, 32'h4, "charge stat");
      #1;
      chk(irq_o, 32'h0, "irq clear");
    end
    $display("charge test done");
  endtask : t_charge
  task automatic t_pair();
    int k;
    for (int i = 0; i < 8; i++) begin
      wr(`FMC_ADR_CFG, 32'h00C0 | 32'((i % 4) << ((i < 4) ? 14 : 12)) | 32'((i % 2) << 16));
      pulse((i < 4) ? 2 : 3);
      k = 0;
      do begin
        sample();
        k++;
      end while (((i < 4) ? tof_second_go_o : temp_second_go_o) !== 1'b1 && k < 200);
      chk(k, ((i % 2) ? H60 : H50) * (i % 4 + 2) + 1, "pair delay");
    end
    rd(`FMC_ADR_STAT, 32'h2, "pair stat");
    $display("pair test done");
  endtask : t_pair
  task automatic t_osc();
    int k;
    wr(`FMC_ADR_CFG, 32'h0000_00C0);
    #1;
    chk({hs_osc_en_o, hs_osc_ready_o}, 32'h1, "osc off");
    wr(`FMC_ADR_CFG, 32'h0000_02C0);
    #1;
    chk({hs_osc_en_o, hs_osc_ready_o}, 32'h3, "osc on");
    for (int m = 2; m < 8; m++) begin
      wr(`FMC_ADR_CFG, 32'h0000_00C0 | 32'(m << 9));
      meas_active_i <= 1'b1;
      pulse(0);
      k = 0;
      do begin
        sample();
        k++;
      end while (hs_osc_ready_o !== 1'b1 && k < 50);
      chk(k, OS[(m > 5) ? 3 : m - 2] + 1, "osc settle");
      chk(hs_osc_en_o, 32'h1, "osc en");
      @(posedge clk_i);
      meas_active_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      chk({hs_osc_en_o, hs_osc_ready_o}, 32'h0, "osc stop");
    end
    $display("osc test done");
  endtask : t_osc
  task automatic t_nvm();
    wr(`FMC_ADR_MASK, 32'h1);
    pulse(1);
    rd(`FMC_ADR_STAT, 32'h0, "nvm gated");
    wr(`FMC_ADR_CFG, 32'h0000_01C0);
    pulse(1);
    sample();
    chk(irq_o, 32'h1, "nvm irq");
    rd(`FMC_ADR_STAT, 32'h1, "nvm stat");
    #1;
    chk(irq_o, 32'h0, "nvm clear");
    $display("nvm test done");
  endtask : t_nvm
  task automatic t_fire();
    for (int i = 0; i < 4; i++) begin
      wr(`FMC_ADR_CFG, i[1] ? 32'h0002_00C0 : 32'h0000_00C0);
      {fire_up_act_i, fire_down_act_i, fire_pulse_i} <= {~i[0], i[0], 1'b1};
      repeat (2) @(posedge clk_i);
      #1;
      chk(i[0] ? {fire_down_o, fire_down_oe_o, fire_up_o, fire_up_oe_o}
               : {fire_up_o, fire_up_oe_o, fire_down_o, fire_down_oe_o},
          {3'b110, i[1]}, "fire idle");
    end
    $display("fire test done");
  endtask : t_fire
  // ----------------------------------------------------------------
  // run
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    fails++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_fields();
    t_charge();
    t_pair();
    t_osc();
    t_nvm();
    t_fire();
    test_done();
  end
endmodule : testbench
`default_nettype wire
